// >>> hdl/ram_bank_defines.vh
// Behaviour
// RULE_01: jump sum replaces low pc byte
// RULE_02: low byte carry increments high pc byte
// RULE_03: low byte borrow leaves high byte alone
// RULE_04: 1K bytes RAM in five banks
// RULE_05: bank zero 080H-0FFH is system window
// RULE_06: banks one-four map as general RAM; bank four maps only 00H-7FH
// RULE_07: direct accesses use selected bank number
// RULE_08: interrupt entry saves bank, keeps it selected
// RULE_09: interrupt return reloads saved bank
// RULE_10: bank-zero instructions always address bank zero
// RULE_11: sixteen return-stack slots as byte pairs
// RULE_12: bank number in low three bits, 087H
// RULE_13: bank values five-seven select no RAM
// RULE_14: program counter wraps within 14 bits
`ifndef RAM_BANK_DEFINES_VH
`define RAM_BANK_DEFINES_VH

// physical RAM
`define RAM_DEPTH 1024
`define RAM_AW 10
`define RAM_BANK1_BASE 10'h080
`define RAM_BANK2_BASE 10'h180
`define RAM_BANK3_BASE 10'h280
`define RAM_BANK4_BASE 10'h380

// bank codes
`define BANK_W 3
`define BANK_ZERO 3'h0
`define BANK_ONE 3'h1
`define BANK_TWO 3'h2
`define BANK_THREE 3'h3
`define BANK_FOUR 3'h4

// system register window inside bank zero
`define SYS_BANK_SEL 8'h87
`define SYS_PC_LOW 8'h93
`define SYS_PC_HIGH 8'h94
`define SYS_STACK_TOP 3'h7
`define STACK_SLOTS 16
`define STACK_LAST 4'hF

// program counter
`define PC_HIGH_W 6
`define PC_W 14

// reset values
`define BANK_SEL_RST 3'h0
`define PC_LOW_RST 8'h00
`define PC_HIGH_RST 6'h00
`define SLOT_RST 14'h0000

// APB register offsets
`define APB_AW 12
`define APB_BANK_SEL 12'h000
`define APB_SAVED_BANK 12'h004
`define APB_PC_LOW 12'h008
`define APB_PC_HIGH 12'h00C
`define APB_STATUS 12'h010
`define APB_STACK_BASE 6'h01
`define APB_STACK_HI 6'h00

`endif

// >>> hdl/bank_ram.v
`timescale 1ns/1ps
`include "ram_bank_defines.vh"

module bank_ram (
    input wire clk,
    input wire wr_en,
    input wire [`RAM_AW-1:0] addr,
    input wire [7:0] wr_data,
    output wire [7:0] rd_data
);

    reg [7:0] mem [0:`RAM_DEPTH-1];

    // synchronous write, asynchronous read
    always @(posedge clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end

    assign rd_data = mem[addr];

endmodule

// >>> hdl/ram_bank_and_pc_jump_table.v
`timescale 1ns/1ps
`include "ram_bank_defines.vh"

module ram_bank_and_pc_jump_table (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`APB_AW-1:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire mem_req,
    input wire mem_we,
    input wire bank_zero_op,
    input wire [7:0] mem_addr,
    input wire [7:0] mem_wdata,
    output wire [7:0] mem_rdata,
    output wire mem_ack,
    input wire jump_add,
    input wire jump_sub,
    input wire [7:0] acc_value,
    input wire int_entry,
    input wire int_return,
    output wire [`PC_W-1:0] pc_value,
    output wire [`BANK_W-1:0] active_bank,
    output wire int_active
);

    reg [`BANK_W-1:0] bank_sel_reg;
    reg [`BANK_W-1:0] bank_sel_next;
    reg [`BANK_W-1:0] saved_bank_reg;
    reg [`BANK_W-1:0] saved_bank_next;
    reg int_active_reg;
    reg int_active_next;
    reg [7:0] pc_low_reg;
    reg [7:0] pc_low_next;
    reg [`PC_HIGH_W-1:0] pc_high_reg;
    reg [`PC_HIGH_W-1:0] pc_high_next;
    reg [7:0] mem_rdata_reg;
    reg [7:0] mem_rdata_next;
    reg mem_ack_reg;
    reg [31:0] prdata_reg;
    reg [31:0] prdata_next;
    reg apb_err_reg;
    reg apb_err_next;

    wire [`BANK_W-1:0] eff_bank;
    wire sys_hit;
    reg ram_hit;
    reg [`RAM_AW-1:0] ram_index;
    wire [7:0] ram_rdata;
    wire ram_wr;
    reg [7:0] sys_rdata;
    wire core_sys_wr;
    wire core_wr_bank;
    wire core_wr_pc_low;
    wire core_wr_pc_high;
    wire core_in_stack;
    wire [3:0] core_slot;
    wire [8:0] jump_sum;
    wire [`PC_HIGH_W-1:0] pc_high_inc;
    wire bank_valid;
    wire at_bank_sel;
    wire at_pc_low;
    wire at_pc_high;
    wire core_rd;
    wire jump_carry;
    wire [7:0] jump_diff;
    wire mem_ack_next;

    wire apb_setup;
    wire apb_write;
    wire apb_in_stack;
    wire [3:0] apb_slot;
    reg apb_hit;
    reg apb_ro;
    reg [31:0] apb_rmux;
    wire apb_wr_bank;
    wire apb_wr_pc_low;
    wire apb_wr_pc_high;

    wire [`STACK_SLOTS*`PC_W-1:0] slot_flat;

    // core side address path
    assign eff_bank = bank_zero_op ? `BANK_ZERO : // [RULE_10]
        bank_sel_reg; // [RULE_07]
    assign sys_hit = (eff_bank == `BANK_ZERO) && mem_addr[7]; // [RULE_05]
    // status bit: the current select reaches RAM
    assign bank_valid = (bank_sel_reg <= `BANK_FOUR);

    always @* begin
        ram_hit = 1'b0;
        ram_index = {`RAM_AW{1'b0}};
        if (eff_bank == `BANK_ZERO) begin
            ram_hit = !mem_addr[7]; // [RULE_05]
            ram_index = {3'h0, mem_addr[6:0]};
        end else if (eff_bank == `BANK_ONE) begin
            ram_hit = 1'b1; // [RULE_06]
            ram_index = `RAM_BANK1_BASE + {2'b00, mem_addr};
        end else if (eff_bank == `BANK_TWO) begin
            ram_hit = 1'b1; // [RULE_06]
            ram_index = `RAM_BANK2_BASE + {2'b00, mem_addr};
        end else if (eff_bank == `BANK_THREE) begin
            ram_hit = 1'b1; // [RULE_06]
            ram_index = `RAM_BANK3_BASE + {2'b00, mem_addr};
        end else if (eff_bank == `BANK_FOUR) begin
            // only 380H-3FFH exist in bank four
            ram_hit = !mem_addr[7]; // [RULE_06]
            ram_index = `RAM_BANK4_BASE + {3'h0, mem_addr[6:0]};
        end else begin
            // codes five to seven reach nothing
            ram_hit = 1'b0; // [RULE_13]
            ram_index = {`RAM_AW{1'b0}};
        end
    end

    assign ram_wr = mem_req && mem_we && ram_hit; // [RULE_13]

    bank_ram u_bank_ram ( // [RULE_04]
        .clk(pclk),
        .wr_en(ram_wr),
        .addr(ram_index),
        .wr_data(mem_wdata),
        .rd_data(ram_rdata)
    );

    // system window decode for the core port
    assign at_bank_sel = (mem_addr == `SYS_BANK_SEL);
    assign at_pc_low = (mem_addr == `SYS_PC_LOW);
    assign at_pc_high = (mem_addr == `SYS_PC_HIGH);
    assign core_sys_wr = mem_req && mem_we && sys_hit;
    assign core_wr_bank = core_sys_wr && at_bank_sel;
    assign core_wr_pc_low = core_sys_wr && at_pc_low;
    assign core_wr_pc_high = core_sys_wr && at_pc_high;
    assign core_in_stack = (mem_addr[7:5] == `SYS_STACK_TOP);
    // slot 15 sits lowest, slot 0 at the top pair
    assign core_slot = `STACK_LAST - mem_addr[4:1]; // [RULE_11]

    always @* begin
        sys_rdata = 8'h00;
        if (at_bank_sel) begin
            sys_rdata = {5'h00, bank_sel_reg}; // [RULE_12]
        end else if (at_pc_low) begin
            sys_rdata = pc_low_reg;
        end else if (at_pc_high) begin
            sys_rdata = {2'b00, pc_high_reg};
        end else if (core_in_stack) begin
            if (mem_addr[0]) begin
                sys_rdata = {2'b00, slot_flat[core_slot*`PC_W+8 +: 6]};
            end else begin
                sys_rdata = slot_flat[core_slot*`PC_W +: 8]; // [RULE_11]
            end
        end
    end

    // a read reloads the data, anything else holds it
    assign core_rd = mem_req && !mem_we;

    always @* begin
        mem_rdata_next = mem_rdata_reg;
        if (core_rd) begin
            if (ram_hit) begin
                mem_rdata_next = ram_rdata;
            end else if (sys_hit) begin
                mem_rdata_next = sys_rdata;
            end else begin
                mem_rdata_next = 8'h00; // [RULE_13]
            end
        end
    end

    // computed jump
    assign jump_sum = {1'b0, pc_low_reg} + {1'b0, acc_value};
    assign pc_high_inc = pc_high_reg + {{(`PC_HIGH_W-1){1'b0}}, 1'b1};
    assign jump_carry = jump_sum[8];
    // a borrow never reaches the high byte
    assign jump_diff = pc_low_reg - acc_value;

    // jumps outrank window writes, which outrank APB
    always @* begin
        pc_low_next = pc_low_reg;
        pc_high_next = pc_high_reg;
        if (jump_add) begin
            pc_low_next = jump_sum[7:0]; // [RULE_01]
            if (jump_carry) begin
                // wraps inside the 14-bit space
                pc_high_next = pc_high_inc; // [RULE_02] [RULE_14]
            end
        end else if (jump_sub) begin
            pc_low_next = jump_diff; // [RULE_03]
        end else if (core_wr_pc_low) begin
            pc_low_next = mem_wdata;
        end else if (core_wr_pc_high) begin
            pc_high_next = mem_wdata[`PC_HIGH_W-1:0];
        end else if (apb_wr_pc_low) begin
            pc_low_next = pwdata[7:0];
        end else if (apb_wr_pc_high) begin
            pc_high_next = pwdata[`PC_HIGH_W-1:0];
        end
    end

    // bank select, save and restore
    // return outranks entry when both strobes meet
    always @* begin
        bank_sel_next = bank_sel_reg;
        saved_bank_next = saved_bank_reg;
        int_active_next = int_active_reg;
        if (int_return) begin
            bank_sel_next = saved_bank_reg; // [RULE_09]
            int_active_next = 1'b0;
        end else if (int_entry) begin
            // bank stays as it was on entry
            saved_bank_next = bank_sel_reg; // [RULE_08]
            int_active_next = 1'b1;
        end else if (core_wr_bank) begin
            bank_sel_next = mem_wdata[`BANK_W-1:0]; // [RULE_12]
        end else if (apb_wr_bank) begin
            bank_sel_next = pwdata[`BANK_W-1:0]; // [RULE_12]
        end
    end

    // APB slave, zero wait states
    assign apb_setup = psel && !penable;
    // a refused write is blocked by the flag taken in setup
    assign apb_write = psel && penable && pwrite && !apb_err_reg;
    assign apb_in_stack = (paddr[11:6] == `APB_STACK_BASE) &&
        (paddr[1:0] == 2'b00);
    assign apb_slot = paddr[5:2];
    assign apb_wr_bank = apb_write && (paddr == `APB_BANK_SEL);
    assign apb_wr_pc_low = apb_write && (paddr == `APB_PC_LOW);
    assign apb_wr_pc_high = apb_write && (paddr == `APB_PC_HIGH);

    // offsets not listed fall through to a miss
    always @* begin
        apb_hit = 1'b1;
        apb_ro = 1'b0;
        apb_rmux = 32'h00000000;
        if (paddr == `APB_BANK_SEL) begin
            apb_rmux = {29'h00000000, bank_sel_reg};
        end else if (paddr == `APB_SAVED_BANK) begin
            apb_ro = 1'b1;
            apb_rmux = {29'h00000000, saved_bank_reg};
        end else if (paddr == `APB_PC_LOW) begin
            apb_rmux = {24'h000000, pc_low_reg};
        end else if (paddr == `APB_PC_HIGH) begin
            apb_rmux = {26'h0000000, pc_high_reg};
        end else if (paddr == `APB_STATUS) begin
            apb_ro = 1'b1;
            apb_rmux = {30'h00000000, bank_valid, int_active_reg};
        end else if (apb_in_stack) begin
            apb_rmux = {18'h00000, slot_flat[apb_slot*`PC_W +: `PC_W]};
        end else begin
            apb_hit = 1'b0;
        end
    end

    // read data and error are captured in the setup cycle
    always @* begin
        prdata_next = prdata_reg;
        apb_err_next = apb_err_reg;
        if (apb_setup) begin
            prdata_next = pwrite ? 32'h00000000 : apb_rmux;
            apb_err_next = !apb_hit || (pwrite && apb_ro);
            if (!apb_hit) begin
                prdata_next = 32'h00000000;
            end
        end
    end

    // return stack slots
    genvar i;
    generate
        for (i = 0; i < `STACK_SLOTS; i = i + 1) begin : g_slot
            reg [`PC_W-1:0] slot_reg;
            reg [`PC_W-1:0] slot_next;
            wire core_hit;
            wire apb_hit_slot;
            assign core_hit = core_sys_wr && core_in_stack &&
                ({28'h0000000, core_slot} == i);
            assign apb_hit_slot = apb_write && apb_in_stack &&
                ({28'h0000000, apb_slot} == i);
            // core port wins over APB in the same cycle
            always @* begin
                slot_next = slot_reg;
                if (core_hit && !mem_addr[0]) begin
                    slot_next[7:0] = mem_wdata; // [RULE_11]
                end else if (core_hit) begin
                    slot_next[`PC_W-1:8] = mem_wdata[5:0]; // [RULE_11]
                end else if (apb_hit_slot) begin
                    slot_next = pwdata[`PC_W-1:0];
                end
            end
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    slot_reg <= `SLOT_RST;
                end else begin
                    slot_reg <= slot_next;
                end
            end
            assign slot_flat[i*`PC_W +: `PC_W] = slot_reg;
        end
    endgenerate

    // one acknowledge for every sampled request
    assign mem_ack_next = mem_req;

    // state registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bank_sel_reg <= `BANK_SEL_RST;
            saved_bank_reg <= `BANK_SEL_RST;
            int_active_reg <= 1'b0;
            pc_low_reg <= `PC_LOW_RST;
            pc_high_reg <= `PC_HIGH_RST;
            mem_rdata_reg <= 8'h00;
            mem_ack_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            apb_err_reg <= 1'b0;
        end else begin
            bank_sel_reg <= bank_sel_next;
            saved_bank_reg <= saved_bank_next;
            int_active_reg <= int_active_next;
            pc_low_reg <= pc_low_next;
            pc_high_reg <= pc_high_next;
            mem_rdata_reg <= mem_rdata_next;
            mem_ack_reg <= mem_ack_next;
            prdata_reg <= prdata_next;
            apb_err_reg <= apb_err_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = psel && penable && apb_err_reg;
    assign mem_rdata = mem_rdata_reg;
    assign mem_ack = mem_ack_reg;
    assign pc_value = {pc_high_reg, pc_low_reg};
    assign active_bank = bank_sel_reg;
    assign int_active = int_active_reg;

endmodule

// >>> dv/ram_bank_and_pc_jump_table_asserts.sv
`timescale 1ns/1ps
`include "ram_bank_defines.vh"
module ram_bank_asserts (
    input wire pclk,
    input wire presetn,
    input wire mem_req,
    input wire mem_we,
    input wire bank_zero_op,
    input wire [7:0] mem_addr,
    input wire [7:0] mem_wdata,
    input wire [7:0] mem_rdata,
    input wire jump_add,
    input wire jump_sub,
    input wire [7:0] acc_value,
    input wire int_entry,
    input wire int_return,
    input wire [`PC_W-1:0] pc_value,
    input wire [`BANK_W-1:0] active_bank,
    input wire int_active
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire [8:0] sum9 = {1'b0, pc_value[7:0]} + {1'b0, acc_value};
    wire [7:0] sum8 = pc_value[7:0] + acc_value;
    wire [7:0] diff8 = pc_value[7:0] - acc_value;
    wire [5:0] pc_high = pc_value[13:8];
    wire [2:0] wr_bank = mem_wdata[2:0];
    wire no_ram = active_bank > 3'h4 || active_bank == 3'h4 && mem_addr[7];
    reg [2:0] held_bank;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            held_bank <= 3'h0;
        end else if (int_entry && !int_return) begin
            held_bank <= active_bank;
        end
    end
    sequence s_enter;
        int_entry && !int_return;
    endsequence
    sequence s_bank_wr;
        mem_req && mem_we && mem_addr == 8'h87 && !int_entry && !int_return
            && (bank_zero_op || active_bank == 3'h0);
    endsequence
    jump_low_a: assert property (
        jump_add |=> pc_value[7:0] == $past(sum8))
        else $error("jump sum not in low pc byte");
    carry_up_a: assert property (
        jump_add && sum9[8] |=> pc_high == $past(pc_high) + 6'h01)
        else $error("carry did not bump high pc byte");
    no_carry_a: assert property (
        jump_add && !sum9[8] |=> $stable(pc_high))
        else $error("high pc byte moved without carry");
    borrow_keep_a: assert property (
        jump_sub && !jump_add |=> $stable(pc_high)
            && pc_value[7:0] == $past(diff8))
        else $error("borrow altered high pc byte");
    entry_keep_a: assert property (
        s_enter |=> active_bank == $past(active_bank) && int_active)
        else $error("bank changed on interrupt entry");
    restore_bank_a: assert property (
        int_return |=> active_bank == held_bank && !int_active)
        else $error("bank not restored on return");
    bank_write_a: assert property (
        s_bank_wr |=> active_bank == $past(wr_bank))
        else $error("bank select write lost");
    no_ram_a: assert property (
        mem_req && !mem_we && !bank_zero_op && no_ram |=> mem_rdata == 8'h00)
        else $error("unmapped bank read not zero");
endmodule
bind ram_bank_and_pc_jump_table ram_bank_asserts i_asserts (
    .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
    .bank_zero_op(bank_zero_op), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .jump_add(jump_add),
    .jump_sub(jump_sub), .acc_value(acc_value), .int_entry(int_entry),
    .int_return(int_return), .pc_value(pc_value),
    .active_bank(active_bank), .int_active(int_active));

// >>> dv/core_model.sv
`timescale 1ns/1ps
module core_model (
    input wire clk,
    input wire [7:0] mem_rdata,
    input wire mem_ack,
    output logic mem_req,
    output logic mem_we,
    output logic bank_zero_op,
    output logic [7:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic jump_add,
    output logic jump_sub,
    output logic [7:0] acc_value,
    output logic int_entry,
    output logic int_return,
    output logic fault
);
    initial begin
        {mem_req, mem_we, bank_zero_op, mem_addr, mem_wdata} = 19'h00000;
        {jump_add, jump_sub, int_entry, int_return, acc_value, fault} = 13'h0;
    end
    task automatic access(input logic we, input logic bz,
                          input logic [7:0] a, input logic [7:0] wd,
                          output logic [7:0] rd);
        int n;
        @(posedge clk);
        {mem_req, mem_we, bank_zero_op, mem_addr, mem_wdata} <=
            {1'b1, we, bz, a, wd};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!mem_ack && n < 20);
        rd = mem_rdata;
        fault <= !mem_ack;
        // released address and data show the inverse; mem_we and bank_zero_op keep their value
        {mem_req, mem_addr, mem_wdata} <= {1'b0, ~a, ~wd};
    endtask
    // one-hot: add, sub, entry, return
    task automatic pulse(input logic [3:0] s, input logic [7:0] acc);
        @(posedge clk);
        {jump_add, jump_sub, int_entry, int_return, acc_value} <= {s, acc};
        @(posedge clk);
        {jump_add, jump_sub, int_entry, int_return, acc_value} <= {4'h0, ~acc};
        @(negedge clk);
    endtask
endmodule

// >>> dv/test_ram_bank_and_pc_jump_table.sv
`timescale 1ns/1ps
`include "ram_bank_defines.vh"
module test_ram_bank_and_pc_jump_table;
    logic pclk, presetn, psel, penable, pwrite, hang, err;
    logic [`APB_AW-1:0] paddr;
    logic [31:0] pwdata, rd;
    logic [7:0] m;
    wire [31:0] prdata;
    wire pready, pslverr, mem_req, mem_we, bank_zero_op, mem_ack, fault;
    wire jump_add, jump_sub, int_entry, int_return, int_active;
    wire [7:0] mem_addr, mem_wdata, mem_rdata, acc_value;
    wire [`PC_W-1:0] pc_value;
    wire [`BANK_W-1:0] active_bank;
    int n_errors, compares, i;
    ram_bank_and_pc_jump_table i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_we(mem_we), .bank_zero_op(bank_zero_op), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .jump_add(jump_add), .jump_sub(jump_sub), .acc_value(acc_value),
        .int_entry(int_entry), .int_return(int_return),
        .pc_value(pc_value), .active_bank(active_bank),
        .int_active(int_active));
    core_model core (
        .clk(pclk), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .mem_req(mem_req), .mem_we(mem_we), .bank_zero_op(bank_zero_op),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .jump_add(jump_add),
        .jump_sub(jump_sub), .acc_value(acc_value), .int_entry(int_entry),
        .int_return(int_return), .fault(fault));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic end_sim();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge hang or posedge fault) begin
        n_errors++;
        end_sim();
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!pready && n < 20);
        rd = prdata;
        err = pslverr;
        hang = !pready;
        {psel, penable, pwdata} <= {2'b00, ~wd};
    endtask
    initial begin
        {presetn, psel, penable, pwrite, hang, err} = 6'h00;
        {paddr, pwdata} = 44'h0;
        n_errors = 0;
        compares = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `APB_STATUS, 0);
        chk(rd, 32'h2);
        apb(1, `APB_PC_LOW, 32'hF8);
        core.pulse(4'h8, 8'h10);
        chk({18'h0, pc_value}, 32'h0108);
        core.pulse(4'h4, 8'h10);
        chk({18'h0, pc_value}, 32'h01F8);
        core.pulse(4'h8, 8'h07);
        chk({18'h0, pc_value}, 32'h01FF);
        apb(1, `APB_PC_HIGH, 32'h3F);
        core.pulse(4'h8, 8'h01);
        chk({18'h0, pc_value}, 32'h0);
        for (i = 0; i < 5; i++) begin
            core.access(1, 1, `SYS_BANK_SEL, i[7:0], m);
            chk({29'h0, active_bank}, i);
            core.access(1, 0, 8'h10, 8'hA0 + i[7:0], m);
        end
        for (i = 0; i < 5; i++) begin
            apb(1, `APB_BANK_SEL, i);
            core.access(0, 0, 8'h10, 8'h00, m);
            chk({24'h0, m}, 32'hA0 + i);
        end
        core.access(1, 0, 8'h90, 8'h5A, m);
        core.access(0, 0, 8'h90, 8'h00, m);
        chk({24'h0, m}, 32'h0);
        apb(1, `APB_BANK_SEL, 1);
        core.access(1, 0, 8'h90, 8'h5A, m);
        core.access(0, 0, 8'h90, 8'h00, m);
        chk({24'h0, m}, 32'h5A);
        core.access(0, 1, 8'h10, 8'h00, m);
        chk({24'h0, m}, 32'hA0);
        core.access(0, 1, `SYS_PC_LOW, 8'h00, m);
        chk({24'h0, m}, 32'h0);
        core.access(0, 1, `SYS_BANK_SEL, 8'h00, m);
        chk({24'h0, m}, 32'h1);
        core.access(1, 1, 8'hE0, 8'h34, m);
        core.access(1, 1, 8'hE1, 8'h12, m);
        apb(0, 12'h07C, 0);
        chk(rd, 32'h1234);
        apb(1, 12'h040, 32'h2ABC);
        core.access(0, 1, 8'hFF, 8'h00, m);
        chk({24'h0, m}, 32'h2A);
        apb(0, 12'h020, 0);
        chk({31'h0, err}, 32'h1);
        apb(1, `APB_BANK_SEL, 32'hFF);
        apb(0, `APB_BANK_SEL, 0);
        chk(rd, 32'h7);
        core.access(0, 0, 8'h10, 8'h00, m);
        chk({24'h0, m}, 32'h0);
        apb(1, `APB_BANK_SEL, 2);
        core.pulse(4'h2, 8'h00);
        chk({28'h0, int_active, active_bank}, 32'hA);
        core.access(1, 1, `SYS_BANK_SEL, 8'h04, m);
        core.pulse(4'h1, 8'h00);
        chk({28'h0, int_active, active_bank}, 32'h2);
        end_sim();
    end
endmodule
